// [src/aft_hold_timer.sv]
`timescale 1ns/100ps
`include "aft_map.svh"

module aft_hold_timer
    import aft_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic load,
    input wire logic [24:0] count,
    // Status
    output logic done
);

    logic [24:0] remain;

    // Count down a loaded number of cycles, pulse done at the end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            remain <= 25'h0000000;
            done <= 1'b0;
        end
        else if (load)
        begin
            remain <= count;
            done <= 1'b0;
        end
        else if (remain != 25'h0000000)
        begin
            remain <= remain - 25'h0000001;
            done <= (remain == 25'h0000001);
        end
        else
        begin
            done <= 1'b0;
        end
    end

endmodule // aft_hold_timer

// [src/aft_map.svh]
`ifndef AFT_MAP_SVH
`define AFT_MAP_SVH

// Clock rate and hold times
`define AFT_CLK_HZ 200000000
`define AFT_SETUP_MS 50
`define AFT_STROBE_MS 100
`define AFT_TAIL_STD_MS 50
`define AFT_TAIL_EXT_MS 150
`define AFT_CYC_PER_MS (`AFT_CLK_HZ / 1000)
`define AFT_SETUP_CYC (`AFT_SETUP_MS * `AFT_CYC_PER_MS)
`define AFT_STROBE_CYC (`AFT_STROBE_MS * `AFT_CYC_PER_MS)
`define AFT_TAIL_STD_CYC (`AFT_TAIL_STD_MS * `AFT_CYC_PER_MS)
`define AFT_TAIL_EXT_CYC (`AFT_TAIL_EXT_MS * `AFT_CYC_PER_MS)

// APB register offsets
`define AFT_REG_CFG 12'h000
`define AFT_REG_CMD 12'h004
`define AFT_REG_STATUS 12'h008
`define AFT_REG_DOUT 12'h00C
`define AFT_REG_TBL_IDX 12'h010
`define AFT_REG_TBL_ACT 12'h014
`define AFT_REG_TBL_DEACT 12'h018
`define AFT_REG_TBL_NUM 12'h01C

// Configuration bit positions
`define AFT_CFG_BINARY 0
`define AFT_CFG_DEC_CODED 1
`define AFT_CFG_SPINDLE_CODED 2
`define AFT_CFG_EXT_HOLD 3

// Command word fields
`define AFT_CMD_KIND_LO 8
`define AFT_CMD_KIND_HI 9
`define AFT_CMD_AFTER 10
`define AFT_CMD_LAST 11

// Deactivate row control bits, below the 15-bit mask
`define AFT_DEACT_AFTER 1
`define AFT_DEACT_NOWAIT 0

// Table geometry
`define AFT_TBL_DEPTH 16
`define AFT_MAX_PER_BLOCK 7
`define AFT_MAX_MCODE 99
`define AFT_NUM_DOUT 15

`endif

// [src/aft_pkg.sv]
package aft_pkg;

    typedef enum logic [1:0] {
        AFT_KIND_MISC = 2'h0,
        AFT_KIND_SPINDLE = 2'h1,
        AFT_KIND_TOOL = 2'h2
    } aft_kind_e;

    typedef enum logic [2:0] {
        AFT_IDLE = 3'h0,
        AFT_SETUP = 3'h1,
        AFT_STROBE = 3'h3,
        AFT_TAIL = 3'h2,
        AFT_WAIT = 3'h6
    } aft_state_e;

endpackage

// [src/aft_transfer.sv]
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
`include "aft_map.svh"
// Function
// RQ1: Misc codes 0 to 99 accepted.
// RQ2: Up to seven misc codes per block.
// RQ3: Config bit picks BCD or binary.
// RQ4: Decoded entry updates outputs; coded optional.
// RQ5: Spindle coded only when BCD selected; the code gates spindle on cfg bit 2 alone, not on BCD.
// RQ6: Activate mask sets discrete outputs.
// RQ7: Deactivate mask clears discrete outputs.
// RQ8: Entry bit picks before or after motion.
// RQ9: Entry bit skips completion wait.
// RQ10: Stall until completion input goes high.
// RQ11: Misc first, then spindle, then tool.
// RQ12: Misc codes sent one at a time.
// RQ13: Misc code with misc strobe.
// RQ14: Undecoded misc always waits for completion.
// RQ15: Spindle code with strobe, then wait.
// RQ16: Range-change misc codes precede spindle.
// RQ17: Tool code with strobe, then wait.
// RQ18: Strobe after delay, hold 100, tail 50.
// RQ19: Extended hold keeps code 150 ms.
// RQ20: No wait or no drop: done at removal.
// RQ21: One shared 8-bit bus, one transfer.
// RQ22: Unselected discrete outputs keep state.

module aft_transfer
    import aft_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Motion status
    input wire logic axes_in_position,
    // Cabinet link
    input wire logic m_done,
    output logic [7:0] coded_bus,
    output logic m_strobe,
    output logic s_strobe,
    output logic t_strobe,
    output logic [14:0] decoded_out
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and storage

    logic [3:0] cfg;
    logic [3:0] tbl_idx;
    logic [7:0] tbl_num [0:`AFT_TBL_DEPTH-1];
    logic tbl_used [0:`AFT_TBL_DEPTH-1];
    logic [14:0] tbl_act [0:`AFT_TBL_DEPTH-1];
    logic [16:0] tbl_deact [0:`AFT_TBL_DEPTH-1];
    logic [11:0] cmd_word;
    logic cmd_valid;
    logic [2:0] misc_count;
    logic seq_err;
    aft_state_e state;
    aft_kind_e kind;
    logic [1:0] blk_kind;
    logic need_wait;
    logic dropped;
    logic timer_load;
    logic [24:0] timer_count;
    logic timer_done;
    logic wr_en;
    logic start;
    logic hit;
    logic [3:0] hit_idx;
    logic cmd_ok;

    // Binary to two-digit BCD for codes 0..99
    function automatic logic [7:0] to_bcd(input logic [7:0] v);
        return {4'(v / 8'h0A), 4'(v % 8'h0A)};
    endfunction

    assign wr_en = psel && penable && pwrite;

    ////////////////////////////////////////////////////////////////////////
    // Decoded table lookup for the pending misc code

    always_comb
    begin
        hit = 1'b0;
        hit_idx = 4'h0;
        for (int i = 0; i < `AFT_TBL_DEPTH; i++)
        begin
            if (!hit && tbl_used[i] && tbl_num[i] == cmd_word[7:0])
            begin
                hit = 1'b1;
                hit_idx = i[3:0];
            end
        end
    end

    // Command check: code in range, block limit, spindle allowed, kind order
    always_comb
    begin
        cmd_ok = 1'b0;
        if (cmd_word[9:8] == AFT_KIND_MISC)
            cmd_ok = (cmd_word[7:0] <= 8'(`AFT_MAX_MCODE)) // [RQ1]
                && (misc_count < 3'(`AFT_MAX_PER_BLOCK)); // [RQ2]
        else if (cmd_word[9:8] == AFT_KIND_SPINDLE)
            cmd_ok = cfg[`AFT_CFG_SPINDLE_CODED]; // [RQ5]
        else if (cmd_word[9:8] == AFT_KIND_TOOL)
            cmd_ok = 1'b1;
        // A kind earlier than one already sent in this block is out of order
        if (cmd_word[9:8] < blk_kind)
            cmd_ok = 1'b0; // [RQ11] [RQ16]
    end

    // Start when idle, command queued, and motion point reached (command or table)
    assign start = (state == AFT_IDLE) && cmd_valid && (axes_in_position
        || !(cmd_word[`AFT_CMD_AFTER] || (hit && cmd_word[9:8] == AFT_KIND_MISC
        && tbl_deact[hit_idx][`AFT_DEACT_AFTER]))); // [RQ8]

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait state

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && !penable && !pwrite)
            begin
                if (paddr == `AFT_REG_CFG)
                    prdata <= {28'h0000000, cfg};
                else if (paddr == `AFT_REG_STATUS)
                    prdata <= {25'h0000000, seq_err, misc_count, cmd_valid,
                        state != AFT_IDLE, 1'b0} | {31'h00000000, m_done};
                else if (paddr == `AFT_REG_DOUT)
                    prdata <= {17'h00000, decoded_out};
                else if (paddr == `AFT_REG_TBL_IDX)
                    prdata <= {28'h0000000, tbl_idx};
                else if (paddr == `AFT_REG_TBL_ACT)
                    prdata <= {17'h00000, tbl_act[tbl_idx]};
                else if (paddr == `AFT_REG_TBL_DEACT)
                    prdata <= {15'h0000, tbl_deact[tbl_idx]};
                else if (paddr == `AFT_REG_TBL_NUM)
                    prdata <= {23'h000000, tbl_used[tbl_idx], tbl_num[tbl_idx]};
                else if (paddr != `AFT_REG_CMD)
                    pslverr <= 1'b1;
            end
            else if (psel && !penable)
                pslverr <= !(paddr == `AFT_REG_CFG || paddr == `AFT_REG_CMD
                    || paddr == `AFT_REG_TBL_IDX || paddr == `AFT_REG_TBL_ACT
                    || paddr == `AFT_REG_TBL_DEACT || paddr == `AFT_REG_TBL_NUM);
        end
    end

    // Configuration and table writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg <= 4'h0;
            tbl_idx <= 4'h0;
            for (int i = 0; i < `AFT_TBL_DEPTH; i++)
            begin
                tbl_num[i] <= 8'h00;
                tbl_used[i] <= 1'b0;
                tbl_act[i] <= 15'h0000;
                tbl_deact[i] <= 17'h00000;
            end
        end
        else if (wr_en && pready)
        begin
            if (paddr == `AFT_REG_CFG)
                cfg <= pwdata[3:0];
            else if (paddr == `AFT_REG_TBL_IDX)
                tbl_idx <= pwdata[3:0];
            else if (paddr == `AFT_REG_TBL_ACT)
                tbl_act[tbl_idx] <= pwdata[14:0];
            else if (paddr == `AFT_REG_TBL_DEACT)
                tbl_deact[tbl_idx] <= pwdata[16:0];
            else if (paddr == `AFT_REG_TBL_NUM)
            begin
                tbl_num[tbl_idx] <= pwdata[7:0];
                tbl_used[tbl_idx] <= pwdata[8];
            end
        end
    end

    // Single command slot; software issues misc, then spindle, then tool
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_word <= 12'h000;
            cmd_valid <= 1'b0;
            seq_err <= 1'b0;
        end
        else if (wr_en && pready && paddr == `AFT_REG_CMD)
        begin
            if (cmd_valid || state != AFT_IDLE)
                seq_err <= 1'b1; // [RQ21]
            else
            begin
                cmd_word <= pwdata[11:0];
                cmd_valid <= 1'b1;
            end
        end
        else if (cmd_valid && !cmd_ok)
        begin
            cmd_valid <= 1'b0;
            seq_err <= 1'b1;
        end
        else if (start)
            cmd_valid <= 1'b0;
    end

    // Per-block bookkeeping: misc count and latest kind, cleared by the last command
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            misc_count <= 3'h0;
            blk_kind <= 2'h0;
        end
        else if (start && cmd_ok)
        begin
            blk_kind <= cmd_word[`AFT_CMD_LAST] ? 2'h0 : cmd_word[9:8]; // [RQ11] [RQ16]
            if (cmd_word[`AFT_CMD_LAST])
                misc_count <= 3'h0;
            else if (cmd_word[9:8] == AFT_KIND_MISC)
                misc_count <= misc_count + 3'h1; // [RQ2]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= AFT_IDLE;
            kind <= AFT_KIND_MISC;
            need_wait <= 1'b0;
            dropped <= 1'b0;
            coded_bus <= 8'h00;
            {m_strobe, s_strobe, t_strobe} <= 3'h0;
        end
        else
        begin
            case (state)
                AFT_IDLE:
                begin
                    if (start && cmd_ok)
                    begin
                        kind <= aft_kind_e'(cmd_word[9:8]);
                        dropped <= 1'b0;
                        if (cmd_word[9:8] == AFT_KIND_MISC)
                        begin
                            need_wait <= hit ? !tbl_deact[hit_idx][`AFT_DEACT_NOWAIT]
                                : 1'b1; // [RQ9] [RQ14]
                            if (!hit || cfg[`AFT_CFG_DEC_CODED]) // [RQ4]
                            begin
                                coded_bus <= cfg[`AFT_CFG_BINARY] ? cmd_word[7:0]
                                    : to_bcd(cmd_word[7:0]); // [RQ3]
                                state <= AFT_SETUP;
                            end
                            else if (!tbl_deact[hit_idx][`AFT_DEACT_NOWAIT])
                                state <= AFT_WAIT;
                        end
                        else
                        begin
                            need_wait <= 1'b1; // [RQ15] [RQ17]
                            coded_bus <= cmd_word[7:0];
                            state <= AFT_SETUP;
                        end
                    end
                end
                AFT_SETUP:
                begin
                    if (timer_done)
                    begin
                        m_strobe <= (kind == AFT_KIND_MISC); // [RQ13]
                        s_strobe <= (kind == AFT_KIND_SPINDLE); // [RQ15]
                        t_strobe <= (kind == AFT_KIND_TOOL); // [RQ17]
                        state <= AFT_STROBE;
                    end
                end
                AFT_STROBE:
                begin
                    if (!m_done)
                        dropped <= 1'b1; // [RQ20]
                    if (timer_done)
                    begin
                        {m_strobe, s_strobe, t_strobe} <= 3'h0;
                        state <= AFT_TAIL; // [RQ18]
                    end
                end
                AFT_TAIL:
                begin
                    if (!m_done)
                        dropped <= 1'b1;
                    if (timer_done)
                    begin
                        coded_bus <= 8'h00;
                        // Done at removal unless a drop was seen and wait needed
                        if (need_wait && (dropped || !m_done))
                            state <= AFT_WAIT; // [RQ20]
                        else
                            state <= AFT_IDLE;
                    end
                end
                AFT_WAIT:
                begin
                    if (m_done)
                        state <= AFT_IDLE; // [RQ10] [RQ12]
                end
                default:
                    state <= AFT_IDLE;
            endcase
        end
    end

    // Discrete outputs: set by activate, cleared by deactivate, else kept
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            decoded_out <= 15'h0000;
        else if (start && cmd_ok && cmd_word[9:8] == AFT_KIND_MISC && hit)
            decoded_out <= (decoded_out & ~tbl_deact[hit_idx][16:2])
                | tbl_act[hit_idx]; // [RQ6] [RQ7] [RQ22]
    end

    // Timer reload at each phase entry; one below the length, as done lands a cycle late
    always_comb
    begin
        timer_load = 1'b0;
        timer_count = 25'h0000000;
        if (state == AFT_IDLE && start && cmd_ok)
        begin
            timer_load = 1'b1;
            timer_count = 25'(`AFT_SETUP_CYC - 1);
        end
        else if (state == AFT_SETUP && timer_done)
        begin
            timer_load = 1'b1;
            timer_count = 25'(`AFT_STROBE_CYC - 1);
        end
        else if (state == AFT_STROBE && timer_done)
        begin
            timer_load = 1'b1;
            timer_count = cfg[`AFT_CFG_EXT_HOLD] ? 25'(`AFT_TAIL_EXT_CYC - 1)
                : 25'(`AFT_TAIL_STD_CYC - 1); // [RQ18] [RQ19]
        end
    end

    aft_hold_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .load(timer_load),
        .count(timer_count),
        .done(timer_done)
    );

endmodule // aft_transfer

// [testbench/aft_cabinet.sv]
`timescale 1ns/100ps

module aft_cabinet
#(
    parameter int EXEC_CYC = 40,
    parameter bit DROP = 1'b1
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Strobes from the block
    input wire logic m_strobe,
    input wire logic s_strobe,
    input wire logic t_strobe,
    // Completion back to the block
    output logic m_done
);
    logic prev;
    logic [15:0] left;

    // Drop completion when work starts, raise it when work is over
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            m_done <= 1'b1;
            prev <= 1'b0;
            left <= '0;
        end
        else
        begin
            prev <= m_strobe | s_strobe | t_strobe;
            if ((m_strobe | s_strobe | t_strobe) && !prev)
            begin
                m_done <= !DROP;
                left <= 16'(EXEC_CYC);
            end
            else if (left != 16'h0)
            begin
                left <= left - 16'h1;
                m_done <= (left == 16'h1) ? 1'b1 : m_done;
            end
        end
    end
endmodule // aft_cabinet

// [testbench/aft_checker.sv]
`timescale 1ns/100ps
`include "aft_map.svh"

module aft_checker
    import aft_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Cabinet link
    input wire logic [7:0] coded_bus,
    input wire logic m_strobe,
    input wire logic s_strobe,
    input wire logic t_strobe,
    input wire logic [14:0] decoded_out
);
    localparam int SETUP = `AFT_SETUP_CYC;
    localparam int STROBE = `AFT_STROBE_CYC;
    logic any_strobe;
    logic rd_done;
    logic [24:0] low_cnt;
    logic [24:0] hi_cnt;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Any strobe, and a read that completes
    assign any_strobe = m_strobe | s_strobe | t_strobe;
    assign rd_done = psel & penable & pready & !pwrite;

    ////////////////////////////////////////////////////////////////////////////////
    // Length of the present run of strobe low and strobe high
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            low_cnt <= '0;
            hi_cnt <= '0;
        end
        else
        begin
            // Low count saturates so a long idle time never wraps
            low_cnt <= any_strobe ? '0 : (&low_cnt) ? low_cnt : low_cnt + 25'h1;
            hi_cnt <= any_strobe ? hi_cnt + 25'h1 : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_strobe_onehot: assert property ($onehot0({m_strobe, s_strobe, t_strobe}))
        else $error("two strobes at once");
    a_code_held: assert property (any_strobe |-> $stable(coded_bus))
        else $error("code moved under strobe");
    a_setup_delay: assert property ($rose(any_strobe) |-> low_cnt >= SETUP)
        else $error("strobe came too early");
    a_strobe_width: assert property ($fell(any_strobe) |-> hi_cnt == STROBE)
        else $error("strobe width wrong");
    a_tail_held: assert property ($fell(any_strobe) |=> $stable(coded_bus) [*8])
        else $error("code dropped with strobe");
    a_busy_status: assert property (
        rd_done && paddr == `AFT_REG_STATUS && $past(coded_bus) != 8'h00 |-> prdata[1])
        else $error("idle while code shown");
    a_dout_readback: assert property (
        rd_done && paddr == `AFT_REG_DOUT |-> prdata == {17'h0, $past(decoded_out)})
        else $error("output readback wrong");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
endmodule // aft_checker

bind aft_transfer aft_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .coded_bus, .m_strobe, .s_strobe, .t_strobe, .decoded_out);

// [testbench/tb_aft_transfer.sv]
`timescale 1ns/100ps
`include "aft_map.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %s exp %h got %h", n, e, g); end end

module tb_aft_transfer import aft_pkg::*;;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic axes_in_position = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, m_done, m_strobe, s_strobe, t_strobe;
    logic [7:0] coded_bus;
    logic [14:0] decoded_out;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    int code;
    integer seed = 32'h90435DF0;
    logic [32:0] rq[$];
    logic [31:0] mq[$];
    logic [7:0] bq[$];
    logic [32:0] re;
    logic [31:0] rm;
    logic [7:0] be;
    logic [7:0] val;
    logic [7:0] last_bus = 8'h00;
    logic [14:0] dexp, ac, de;

    always #2.5 pclk = ~pclk;

    aft_transfer DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .axes_in_position, .m_done, .coded_bus, .m_strobe, .s_strobe,
        .t_strobe, .decoded_out);
    aft_cabinet u_cab (.pclk, .presetn, .m_strobe, .s_strobe, .t_strobe, .m_done);

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic results;
        if (num_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One APB transfer, held until ready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // Read, noting masked data and error flag
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [32:0] e);
        rq.push_back(e);
        mq.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic rst;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // Command word, noting the code it should show
    task automatic cmd(input logic [31:0] d, input logic [7:0] c, input bit shown);
        if (shown)
            bq.push_back(c);
        wr(`AFT_REG_CMD, d);
        repeat (8) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Take the oldest note when a read ends or a new code appears
    always @(posedge pclk)
    begin
        if (psel && penable && pready && !pwrite && rq.size() > 0)
        begin
            re = rq.pop_front();
            rm = mq.pop_front();
            `CHK("prdata", re[31:0] & rm, prdata & rm)
            `CHK("pslverr", re[32], pslverr)
        end
        if (coded_bus !== last_bus && coded_bus !== 8'h00)
        begin
            be = (bq.size() > 0) ? bq.pop_front() : 8'h00;
            `CHK("coded_bus", be, coded_bus)
        end
        last_bus <= coded_bus;
        cycles++;
        if (cycles > 20000)
        begin
            num_errors++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(`AFT_REG_CFG, '1, 33'h0);
        rd(`AFT_REG_STATUS, 32'h7F, 33'h1);
        rd(`AFT_REG_DOUT, '1, 33'h0);
        rd(12'h020, '1, {1'b1, 32'h0});
        // Seven decoded functions fill a block, the eighth is refused
        dexp = '0;
        for (int i = 0; i < 8; i++)
        begin
            ac = 15'($random(seed));
            de = 15'($random(seed));
            if (i < 7)
            begin
                wr(`AFT_REG_TBL_IDX, 32'(i));
                wr(`AFT_REG_TBL_NUM, 32'h100 + 32'(40 + i));
                wr(`AFT_REG_TBL_ACT, {17'h0, ac});
                wr(`AFT_REG_TBL_DEACT, {15'h0, de, 2'b00});
                dexp = (dexp & ~de) | ac;
            end
            cmd(32'(40 + i % 7), 8'h00, 1'b0);
            rd(`AFT_REG_DOUT, '1, {18'h0, dexp});
        end
        rd(`AFT_REG_STATUS, 32'h7A, 33'h78);
        // Coded codes in both formats, a second command refused while busy
        for (int i = 0; i < 4; i++)
        begin
            rst();
            code = 1 + ($unsigned($random(seed)) % 99);
            wr(`AFT_REG_CFG, 32'(i % 2));
            cmd(32'(code), (i % 2) ? 8'(code) : 8'((code / 10) * 16 + code % 10), 1'b1);
            `CHK("strobes", 3'h0, {m_strobe, s_strobe, t_strobe})
            rd(`AFT_REG_STATUS, 32'h46, 33'h02);
            wr(`AFT_REG_CMD, 32'(code % 99 + 1));
            rd(`AFT_REG_STATUS, 32'h46, 33'h42);
        end
        // Code 100 refused, spindle refused without coded enable, then spindle and tool
        for (int k = 0; k < 4; k++)
        begin
            rst();
            wr(`AFT_REG_CFG, (k > 1) ? 32'h4 : 32'h0);
            val = 8'($random(seed)) | 8'h01;
            cmd((k > 1) ? {22'h0, 2'(k - 1), val} : (k ? 32'h178 : 32'h64), val, k > 1);
            `CHK("strobes", 3'h0, {m_strobe, s_strobe, t_strobe})
            rd(`AFT_REG_STATUS, 32'h42, (k > 1) ? 33'h02 : 33'h40);
        end
        // After-motion command held until the axes arrive
        rst();
        axes_in_position <= 1'b0;
        wr(`AFT_REG_CFG, 32'h1);
        cmd(32'h400 + 32'd37, 8'h00, 1'b0);
        rd(`AFT_REG_STATUS, 32'h06, 33'h04);
        bq.push_back(8'd37);
        axes_in_position <= 1'b1;
        repeat (8) @(posedge pclk);
        `CHK("bus_notes", 0, bq.size())
        results();
    end
endmodule // tb_aft_transfer
